/* File: design/sssp_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sssp_consts.svh"

// Notes on behaviour
// [R1] Below overvoltage: start-up delay, then soft-start ramp. The code gives the first turn-on after reset the recovery delay instead.
// [R2] Status low only when fully on, fault-free.
// [R3] Overvoltage in any state: status released, switch off.
// [R4] Overvoltage turn-off bypasses timers, within 100 ns.
// [R5] After overvoltage clears, wait recovery delay first.
// [R6] Enable, start-up delay, then ramp; total is sum. The code uses the recovery delay on the first enable after reset.
// [R7] Full soft-start also applied after overvoltage recovery.
// [R8] Over-temperature shuts switch, releases status until clear.
// [R9] Undervoltage lockout: switch off, status released.
// [R10] Powered and enable low: switch on, status low.
// [R11] Enable high: switch off, status released.
// [R12] Overvoltage forces switch off regardless of enable.
// [R13] System provides pull-up on the status output.
// [R14] Soft-start ramp lasts nominally 25 ms.
// [R15] Overvoltage recovery delay nominally 20 ms.
// [R16] Flags synchronised; overvoltage also forces off asynchronously.
// [R17] Fault or disable aborts; counters restart from zero.
module sssp_sequencer #(
  parameter sssp_pkg::sssp_cnt_t STARTUP_CYC = sssp_pkg::sssp_cnt_t'(`SSSP_STARTUP_CYC),
  parameter sssp_pkg::sssp_cnt_t RECOV_CYC = sssp_pkg::sssp_cnt_t'(`SSSP_RECOV_CYC),
  parameter sssp_pkg::sssp_cnt_t SOFTSTART_CYC = sssp_pkg::sssp_cnt_t'(`SSSP_SOFTSTART_CYC)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // System enable and comparator flags (asynchronous)
  input wire logic enable_n,
  input wire logic undervoltage_lockout,
  input wire logic overvoltage,
  input wire logic thermal_shutdown,
  // Switch control
  output logic charge_pump_en,
  output logic soft_start_active,
  output logic switch_on,
  output logic switch_on_fast,
  // Open-drain status: output enable low while driving low
  output logic status_o,
  output logic status_oe_n,
  // Observation
  output sssp_pkg::sssp_state_e state
);
  import sssp_pkg::*;

  logic en_n_s;
  logic undervoltage_lockout_s;
  logic ov_s;
  logic tsd_s;
  logic ov_seen_ff;
  logic nxt_ov_seen;
  logic fault;
  sssp_state_e state_ff;
  sssp_state_e nxt_state;
  sssp_cnt_t cnt_ff;
  sssp_cnt_t nxt_cnt;
  logic cp_ff;
  logic nxt_cp;
  logic ss_ff;
  logic nxt_ss;
  logic sw_ff;
  logic nxt_sw;
  logic oe_n_ff;
  logic nxt_oe_n;

  // True once a phase timer has counted its full length of cycles.
  // A limit of zero would wrap, so every timing count must be at least one.
  function automatic logic timer_done(input sssp_cnt_t count, input sssp_cnt_t limit);
    timer_done = (count >= limit - 23'h000001);
  endfunction : timer_done

  // The charge pump and the switch are driven in the ramp and fully-on phases.
  function automatic logic drives_switch(input sssp_state_e st);
    drives_switch = (st == SSSP_ST_RAMP) || (st == SSSP_ST_ON);
  endfunction : drives_switch

  sssp_sync #(.W(4)) u_sync ( // R16
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in({enable_n, undervoltage_lockout, overvoltage, thermal_shutdown}),
    .rst_val(4'hf),
    .sync_out({en_n_s, undervoltage_lockout_s, ov_s, tsd_s})
  );

  assign fault = undervoltage_lockout_s | ov_s | tsd_s; // R8 R9

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 23'h000001;
    case (state_ff)
      SSSP_ST_OFF: begin
        nxt_cnt = '0;
        if (!fault && !en_n_s) begin // R10
          // Returning from overvoltage uses the recovery timer instead.
          nxt_state = ov_seen_ff ? SSSP_ST_RECOVER : SSSP_ST_STARTUP; // R5
        end
      end
      SSSP_ST_STARTUP: begin
        if (timer_done(cnt_ff, STARTUP_CYC)) begin // R1 R6
          nxt_state = SSSP_ST_RAMP;
          nxt_cnt = '0;
        end
      end
      SSSP_ST_RECOVER: begin
        if (timer_done(cnt_ff, RECOV_CYC)) begin // R5 R15
          nxt_state = SSSP_ST_RAMP; // R7
          nxt_cnt = '0;
        end
      end
      SSSP_ST_RAMP: begin
        if (timer_done(cnt_ff, SOFTSTART_CYC)) begin // R14
          nxt_state = SSSP_ST_ON;
          nxt_cnt = '0;
        end
      end
      SSSP_ST_ON: begin
        nxt_cnt = '0;
      end
      default: begin
        nxt_state = SSSP_ST_OFF;
        nxt_cnt = '0;
      end
    endcase
    // Any fault or disable aborts from every state and zeroes the timer.
    if (fault || en_n_s) begin // R3 R11 R12 R17
      nxt_state = SSSP_ST_OFF;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= SSSP_ST_OFF;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Remembers an overvoltage since the last exit from OFF, so that the next
  // turn-on waits the recovery delay rather than the start-up delay.
  always_comb begin
    nxt_ov_seen = ov_seen_ff | ov_s;
    if ((state_ff == SSSP_ST_OFF) && (nxt_state != SSSP_ST_OFF)) begin // R5
      nxt_ov_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ov_seen_ff <= 1'b0;
    end else begin
      ov_seen_ff <= nxt_ov_seen;
    end
  end

  // Outputs are decoded from the next state so that they change on the same
  // edge as the state and never lag it by a cycle.
  always_comb begin
    nxt_cp = drives_switch(nxt_state); // R6
    nxt_ss = (nxt_state == SSSP_ST_RAMP);
    nxt_sw = drives_switch(nxt_state);
    nxt_oe_n = !(nxt_state == SSSP_ST_ON); // R2 R10
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cp_ff <= 1'b0;
      ss_ff <= 1'b0;
      sw_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      cp_ff <= nxt_cp;
      ss_ff <= nxt_ss;
      sw_ff <= nxt_sw;
      oe_n_ff <= nxt_oe_n;
    end
  end

  // The synchroniser and switch register cost three cycles (24 ns); the raw comparator also gates
  // the gate drive so turn-off never waits on the clock.
  assign switch_on_fast = sw_ff & ~overvoltage; // R4 R16
  assign charge_pump_en = cp_ff;
  assign soft_start_active = ss_ff;
  assign switch_on = sw_ff;
  assign status_o = 1'b0;
  assign status_oe_n = oe_n_ff; // R13
  assign state = state_ff;
endmodule : sssp_sequencer

`default_nettype wire

/* File: pkg/sssp_consts.svh */
`ifndef SSSP_CONSTS_SVH
`define SSSP_CONSTS_SVH

// System clock period in ns (125 MHz).
`define SSSP_CLK_PERIOD_NS 8
// Start-up delay after enable, in ms.
`define SSSP_STARTUP_MS 15
// Overvoltage recovery delay, in ms.
`define SSSP_RECOV_MS 20
// Soft-start ramp duration, in ms.
`define SSSP_SOFTSTART_MS 25
// Cycle counts derived from the times above.
`define SSSP_STARTUP_CYC ((`SSSP_STARTUP_MS * 1000000) / `SSSP_CLK_PERIOD_NS)
`define SSSP_RECOV_CYC ((`SSSP_RECOV_MS * 1000000) / `SSSP_CLK_PERIOD_NS)
`define SSSP_SOFTSTART_CYC ((`SSSP_SOFTSTART_MS * 1000000) / `SSSP_CLK_PERIOD_NS)
// Overvoltage turn-off bound in ns; the bypass path meets it combinationally.
`define SSSP_OV_OFF_NS 100
// Timer width, enough for the longest count.
`define SSSP_CNT_W 23

`endif

/* File: pkg/sssp_pkg.sv */
package sssp_pkg;
  typedef enum logic [4:0] {
    SSSP_ST_OFF = 5'h01,
    SSSP_ST_STARTUP = 5'h02,
    SSSP_ST_RECOVER = 5'h04,
    SSSP_ST_RAMP = 5'h08,
    SSSP_ST_ON = 5'h10
  } sssp_state_e;
  typedef logic [22:0] sssp_cnt_t;
endpackage : sssp_pkg

/* File: design/sssp_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a group of independent level flags.
module sssp_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Flags
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_in[i] ^ rst_val[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  // Flags are stored inverted against their safe value so reset lands on it.
  assign sync_out = sync_ff ^ rst_val;
endmodule : sssp_sync

`default_nettype wire

/* File: bench/sssp_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module sssp_sva #(parameter int SS = 15, parameter int ST = 10) (
  // Clock, reset and inputs
  input wire logic clk_sys, srst, enable_n,
  input wire logic undervoltage_lockout, overvoltage, thermal_shutdown,
  // Outputs
  input wire logic charge_pump_en, soft_start_active, switch_on,
  input wire logic switch_on_fast, status_o, status_oe_n,
  input wire sssp_pkg::sssp_state_e state
);
  import sssp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_fast_cut: assert property (overvoltage |-> !switch_on_fast)
    else $error("fast cut");
  chk_ov_off: assert property (overvoltage[*3] |=> !switch_on && status_oe_n)
    else $error("ov off");
  chk_temp_off: assert property (thermal_shutdown[*3] |=> !charge_pump_en && status_oe_n)
    else $error("temp off");
  chk_uv_off: assert property (undervoltage_lockout[*3] |=> !switch_on && status_oe_n)
    else $error("uv off");
  chk_dis_off: assert property (enable_n[*3] |=> !switch_on && status_oe_n)
    else $error("disable off");
  chk_ramp_pump: assert property (soft_start_active |-> charge_pump_en && switch_on)
    else $error("ramp pump");
  chk_status_full: assert property (!status_oe_n |-> switch_on && !soft_start_active && !status_o)
    else $error("status early");
  chk_ramp_len: assert property ($fell(status_oe_n) |->
    $past(soft_start_active, SS) && !$past(switch_on, SS + 1))
    else $error("ramp length");
  chk_start_delay: assert property ($rose(switch_on) && $past(state) == SSSP_ST_STARTUP |->
    $past(state, ST) == SSSP_ST_STARTUP && $past(state, ST + 1) != SSSP_ST_STARTUP)
    else $error("start delay");
endmodule : sssp_sva
bind sssp_sequencer sssp_sva #(.SS(SOFTSTART_CYC), .ST(STARTUP_CYC)) u_sva (.*);
`default_nettype wire

/* File: bench/sssp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sssp_host (
  input wire logic en_req, status_o, status_oe_n,
  output logic enable_n, status_line
);
  // A released line reads high only because the board pull-up holds it.
  assign status_line = status_oe_n ? 1'h1 : status_o;
  assign enable_n = !en_req;
endmodule : sssp_host
`default_nettype wire

/* File: bench/sssp_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sssp_sequencer_tb;
  import sssp_pkg::*;
  logic clk_sys = 0, srst = 1, en_req = 0, uv = 0, ov = 0, ts = 0;
  logic enable_n, cp, ss, sw, swf, st_o, st_oe_n, st_line;
  sssp_state_e state;
  int mismatches = 0, compares = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  sssp_sequencer #(.STARTUP_CYC(23'ha), .RECOV_CYC(23'hc), .SOFTSTART_CYC(23'hf)) uut (
    .clk_sys(clk_sys), .srst(srst), .enable_n(enable_n), .undervoltage_lockout(uv),
    .overvoltage(ov), .thermal_shutdown(ts), .charge_pump_en(cp), .soft_start_active(ss),
    .switch_on(sw), .switch_on_fast(swf), .status_o(st_o), .status_oe_n(st_oe_n),
    .state(state));
  sssp_host host (.en_req(en_req), .status_o(st_o), .status_oe_n(st_oe_n),
    .enable_n(enable_n), .status_line(st_line));
  task automatic chk(input string nm, input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // The 1 ns step lets the combinational fast path settle before a check.
  task automatic drive(input logic e, u, o, t, input int n);
    @(negedge clk_sys);
    en_req = e;
    uv = u;
    ov = o;
    ts = t;
    #1;
    repeat (n) @(negedge clk_sys);
  endtask : drive
  task automatic wait_on;
    for (int i = 0; i < 60 && st_line !== 1'h0; i++) @(negedge clk_sys);
  endtask : wait_on
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 0;
    drive(0, 0, 0, 0, 4);
    chk("idle", st_line, 1'h1);
    drive(1, 0, 0, 0, 0);
    wait_on;
    chk("on", state, SSSP_ST_ON);
    chk("pump", cp, 1'h1);
    chk("ramp done", ss, 1'h0);
    chk("switch", swf, 1'h1);
    drive(1, 0, 1, 0, 0);
    chk("fast", swf, 1'h0);
    drive(1, 0, 1, 0, 4);
    chk("ov", st_line, 1'h1);
    drive(1, 0, 0, 0, 5);
    chk("recov", state, SSSP_ST_RECOVER);
    wait_on;
    chk("on2", st_line, 1'h0);
    drive(1, 0, 0, 1, 4);
    chk("temp", st_line, 1'h1);
    drive(1, 0, 0, 0, 8);
    chk("start", state, SSSP_ST_STARTUP);
    drive(0, 0, 0, 0, 4);
    chk("dis", sw, 1'h0);
    chk("dis state", state, SSSP_ST_OFF);
    drive(1, 0, 0, 0, 12);
    chk("restart", state, SSSP_ST_STARTUP);
    drive(1, 1, 0, 0, 4);
    chk("uv", st_line, 1'h1);
    chk("uv state", state, SSSP_ST_OFF);
    drive(1, 0, 0, 0, 0);
    wait_on;
    chk("on3", st_line, 1'h0);
    complete_run();
  end
endmodule : sssp_sequencer_tb
`default_nettype wire
